// *** tcc_consts.svh ***
// offsets, field positions, reset values and timing counts of the timer
// assumes a byte-addressed 32-bit register bus, one register per word
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_OFS_CTRLA  8'h00
`define TCC_OFS_CTRLB  8'h04
`define TCC_OFS_FORCE  8'h08
`define TCC_OFS_CNTL   8'h0C
`define TCC_OFS_CNTH   8'h10
`define TCC_OFS_CAPL   8'h14
`define TCC_OFS_CAPH   8'h18
`define TCC_OFS_CMPAL  8'h1C
`define TCC_OFS_CMPAH  8'h20
`define TCC_OFS_CMPBL  8'h24
`define TCC_OFS_CMPBH  8'h28
`define TCC_OFS_IRQEN  8'h2C
`define TCC_OFS_FLAGS  8'h30
`define TCC_OFS_PORT   8'h34
`define TCC_CB_FILT    4
`define TCC_CB_EDGE    5
`define TCC_FLG_CAP    0
`define TCC_FLG_CMPA   1
`define TCC_FLG_CMPB   2
`define TCC_RST_MODE   4'h0
`define TCC_RST_CNT    16'h0000
`define TCC_TOP_MAX    16'hFFFF
`define TCC_TOP_8B     16'h00FF
`define TCC_TOP_9B     16'h01FF
`define TCC_TOP_10B    16'h03FF
`define TCC_DIV_SLOW   7'h07
`define TCC_DIV_SLOWER 7'h3F
`define TCC_FILT_LEN   4
`endif

// *** tcc_pkg.sv ***
// types shared by the capture/compare timer files
// assumes tcc_consts.svh is compiled alongside
package tcc_pkg;
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } tcc_ahb_req_t;
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } tcc_ahb_rsp_t;
    typedef enum logic [2:0] {
        TCC_BUS_IDLE  = 3'b001,
        TCC_BUS_WRITE = 3'b010,
        TCC_BUS_READ  = 3'b100
    } tcc_bus_state_t;
endpackage

// *** tcc_capture_filter.sv ***
// capture input noise filter, runs on the system clock
// assumes the pin is already synchronous to clk_sys
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_capture_filter (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic pinIn,
    input  wire logic enable,
    output logic      level
);
    logic [`TCC_FILT_LEN-1:0] samp_q;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            samp_q <= '0;
        else
            samp_q <= {samp_q[`TCC_FILT_LEN-2:0], pinIn};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            level <= 1'b0;
        else if (!enable)
            level <= pinIn;
        else if (&samp_q)
            level <= 1'b1;
        else if (~|samp_q)
            level <= 1'b0;
    end
endmodule // tcc_capture_filter

// *** tcc_compare_chan.sv ***
// one output compare channel: buffer, active value, comparator, state
// assumes tick is the one-cycle timer clock enable
`timescale 1ns/1ps
module tcc_compare_chan (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        tick,
    input  wire logic        block,
    input  wire logic        pwm,
    input  wire logic        wrap,
    input  wire logic [15:0] counter,
    input  wire logic        wrLoad,
    input  wire logic [15:0] wrValue,
    input  wire logic [1:0]  action,
    input  wire logic        forceHit,
    output logic      [15:0] active,
    output logic      [15:0] cpuView,
    output logic             match,
    output logic             outState
);
    logic [15:0] buf_q;
    logic        pend_q;

    assign cpuView = pwm ? buf_q : active;
    assign match   = tick && pend_q;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            buf_q <= '0;
        else if (wrLoad)
            buf_q <= wrValue;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            active <= '0;
        else if (wrLoad && !pwm)
            active <= wrValue;
        else if (pwm && wrap)
            active <= buf_q;
    end

    // equality seen on one tick flags on the next; a counter write mutes it
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            pend_q <= 1'b0;
        else if (tick)
            pend_q <= !block && (counter == active);
    end

    // state survives mode changes; only reset, force, match or wrap actions change it
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            outState <= 1'b0;
        else if (forceHit && !pwm)
        begin
            case (action)
                2'd1:    outState <= !outState;
                2'd2:    outState <= 1'b0;
                2'd3:    outState <= 1'b1;
                default: outState <= outState;
            endcase
        end
        else if (match)
        begin
            case (action)
                2'd1:    outState <= pwm ? outState : !outState;
                2'd2:    outState <= 1'b0;
                2'd3:    outState <= 1'b1;
                default: outState <= outState;
            endcase
        end
        else if (pwm && wrap)
        begin
            case (action)
                2'd2:    outState <= 1'b1;
                2'd3:    outState <= 1'b0;
                default: outState <= outState;
            endcase
        end
    end
endmodule // tcc_compare_chan

// *** tcc_timer.sv ***
// 16-bit timer with input capture and two output compare channels
// assumes one 10 MHz clock, synchronous pins, a single AHB-Lite master
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_consts.svh"
// Operation
// - filter output moves after four equal samples
// - filter adds four system clocks of delay
// - capture off when capture register sets top
// - pin is sampled whoever drives it
// - new capture overwrites capture register always
// - compare equality flags on next timer tick
// - flags request interrupt, clear on service/write
// - channel A may set counter top
// - pulse modes buffer compare, others write direct
// - compare reads bypass the shared high latch
// - high byte to latch, low commits both
// - force acts like match without flag/counter, in non-pulse modes only
// - counter write mutes matches next tick
// - counter written at top runs to max
// - output state kept across mode changes
// - action bits unbuffered, apply from next match
// - reset clears output state to zero
// - nonzero action puts state on pin
// - action zero leaves state unchanged
// - action bits never touch capture logic
// - capture copies counter and sets flag together
// - capture register writable only as top
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    input  tcc_pkg::tcc_ahb_req_t ahbReq,
    output tcc_pkg::tcc_ahb_rsp_t ahbRsp,
    input  wire logic          capturePin,
    input  wire logic [2:0]    irqAck,
    output logic      [2:0]    irqReq,
    output logic      [1:0]    cmpPinOut,
    output logic      [1:0]    cmpPinOe
);
    import tcc_pkg::*;

    tcc_bus_state_t busState_q;
    logic [7:0]  addr_q;
    logic [7:0]  rdData;
    logic        accept;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  wrData;
    logic [7:0]  temp_q;
    logic [3:0]  actions_q;
    logic [3:0]  mode_q;
    logic        filtEn_q;
    logic        edgeRise_q;
    logic [1:0]  clkSel_q;
    logic [2:0]  irqEn_q;
    logic [2:0]  flags_q;
    logic [1:0]  portVal_q;
    logic [1:0]  ddr_q;
    logic [6:0]  div_q;
    logic        tick;
    logic [15:0] cnt_q;
    logic [15:0] cap_q;
    logic        block_q;
    logic        cntWrite;
    logic [15:0] top;
    logic        topHit;
    logic        wrap;
    logic        pwm;
    logic        capTop;
    logic        level;
    logic        levelPrev_q;
    logic        capEvent;
    logic [15:0] actA;
    logic [15:0] viewA;
    logic [15:0] viewB;
    logic        matchA;
    logic        matchB;
    logic        stateA;
    logic        stateB;
    logic [2:0]  flagSet;
    logic [2:0]  flagClr;

    // modes 0, 4, 12 and 13 are the non-pulse ones
    function automatic logic isPwm(input logic [3:0] m);
        return !(m == 4'd0 || m == 4'd4 || m == 4'd12 || m == 4'd13);
    endfunction

    function automatic logic usesCapTop(input logic [3:0] m);
        return m == 4'd8 || m == 4'd10 || m == 4'd12 || m == 4'd14;
    endfunction

    function automatic logic [15:0] topOf(input logic [3:0]  m,
                                          input logic [15:0] a,
                                          input logic [15:0] c);
        if (usesCapTop(m))
            return c;
        case (m)
            4'd1, 4'd5: return `TCC_TOP_8B;
            4'd2, 4'd6: return `TCC_TOP_9B;
            4'd3, 4'd7: return `TCC_TOP_10B;
            4'd4, 4'd9, 4'd11, 4'd15: return a;
            default: return `TCC_TOP_MAX;
        endcase
    endfunction

    // ---- bus slave: writes take no wait, reads take one ----
    assign accept = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready
                    && ahbRsp.hreadyout;
    assign wrEn   = busState_q == TCC_BUS_WRITE;
    assign rdEn   = busState_q == TCC_BUS_READ;
    assign wrData = ahbReq.hwdata[7:0];

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            busState_q       <= TCC_BUS_IDLE;
            addr_q           <= 8'h00;
            ahbRsp.hreadyout <= 1'b1;
            ahbRsp.hresp     <= 1'b0;
            ahbRsp.hrdata    <= 32'h00000000;
        end
        else
        begin
            case (busState_q)
                TCC_BUS_READ:
                begin
                    ahbRsp.hrdata    <= {24'h000000, rdData};
                    ahbRsp.hreadyout <= 1'b1;
                    busState_q       <= TCC_BUS_IDLE;
                end
                default:
                begin
                    if (accept)
                    begin
                        addr_q           <= ahbReq.haddr[7:0];
                        ahbRsp.hreadyout <= ahbReq.hwrite;
                        busState_q       <= ahbReq.hwrite ? TCC_BUS_WRITE
                                                          : TCC_BUS_READ;
                    end
                    else
                        busState_q <= TCC_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        case (addr_q)
            `TCC_OFS_CTRLA: rdData = {4'h0, actions_q};
            `TCC_OFS_CTRLB: rdData = {clkSel_q, edgeRise_q, filtEn_q,
                                      mode_q};
            `TCC_OFS_CNTL:  rdData = cnt_q[7:0];
            `TCC_OFS_CNTH:  rdData = temp_q;
            `TCC_OFS_CAPL:  rdData = cap_q[7:0];
            `TCC_OFS_CAPH:  rdData = temp_q;
            `TCC_OFS_CMPAL: rdData = viewA[7:0];
            `TCC_OFS_CMPAH: rdData = viewA[15:8];
            `TCC_OFS_CMPBL: rdData = viewB[7:0];
            `TCC_OFS_CMPBH: rdData = viewB[15:8];
            `TCC_OFS_IRQEN: rdData = {5'h00, irqEn_q};
            `TCC_OFS_FLAGS: rdData = {5'h00, flags_q};
            `TCC_OFS_PORT:  rdData = {4'h0, ddr_q, portVal_q};
            default:        rdData = 8'h00;
        endcase
    end

    // shared high-byte latch: written by any high write, filled by counter and capture low reads
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            temp_q <= 8'h00;
        else if (wrEn && (addr_q == `TCC_OFS_CNTH || addr_q == `TCC_OFS_CAPH
                 || addr_q == `TCC_OFS_CMPAH || addr_q == `TCC_OFS_CMPBH))
            temp_q <= wrData;
        else if (rdEn && addr_q == `TCC_OFS_CNTL)
            temp_q <= cnt_q[15:8];
        else if (rdEn && addr_q == `TCC_OFS_CAPL)
            temp_q <= cap_q[15:8];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            actions_q  <= 4'h0;
            mode_q     <= `TCC_RST_MODE;
            filtEn_q   <= 1'b0;
            edgeRise_q <= 1'b0;
            clkSel_q   <= 2'd0;
            irqEn_q    <= 3'b000;
            portVal_q  <= 2'b00;
            ddr_q      <= 2'b00;
        end
        else if (wrEn)
        begin
            case (addr_q)
                `TCC_OFS_CTRLA: actions_q <= wrData[3:0];
                `TCC_OFS_CTRLB:
                begin
                    mode_q     <= wrData[3:0];
                    filtEn_q   <= wrData[`TCC_CB_FILT];
                    edgeRise_q <= wrData[`TCC_CB_EDGE];
                    clkSel_q   <= wrData[7:6];
                end
                `TCC_OFS_IRQEN: irqEn_q <= wrData[2:0];
                `TCC_OFS_PORT:
                begin
                    portVal_q <= wrData[1:0];
                    ddr_q     <= wrData[3:2];
                end
                default: ;
            endcase
        end
    end

    // ---- timer clock enable: stop, /1, /8, /64 ----
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            div_q <= 7'h00;
        else
            div_q <= div_q + 7'h01;
    end

    always_comb
    begin
        case (clkSel_q)
            2'd1:    tick = 1'b1;
            2'd2:    tick = (div_q & `TCC_DIV_SLOW) == 7'h00;
            2'd3:    tick = (div_q & `TCC_DIV_SLOWER) == 7'h00;
            default: tick = 1'b0;
        endcase
    end

    // ---- counter ----
    assign pwm      = isPwm(mode_q);
    assign capTop   = usesCapTop(mode_q);
    assign top      = topOf(mode_q, actA, cap_q);
    assign cntWrite = wrEn && addr_q == `TCC_OFS_CNTL;
    // a muted top match lets the count run on through max
    assign topHit   = tick && !block_q && cnt_q == top;
    assign wrap     = topHit || (tick && cnt_q == `TCC_TOP_MAX);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            cnt_q <= `TCC_RST_CNT;
        else if (cntWrite)
            cnt_q <= {temp_q, wrData};
        else if (topHit)
            cnt_q <= `TCC_RST_CNT;
        else if (tick)
            cnt_q <= cnt_q + 16'h0001;
    end

    // held until the next tick, so a stopped timer still mutes it
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            block_q <= 1'b0;
        else if (cntWrite)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    // ---- input capture ----
    tcc_capture_filter u_filter (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pinIn   (capturePin),
        .enable  (filtEn_q),
        .level   (level)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            levelPrev_q <= 1'b0;
        else
            levelPrev_q <= level;
    end

    // action bits are deliberately absent here
    assign capEvent = !capTop && (edgeRise_q ? (level && !levelPrev_q)
                      : (!level && levelPrev_q));

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            cap_q <= 16'h0000;
        else if (capEvent)
            cap_q <= cnt_q;
        else if (wrEn && capTop && addr_q == `TCC_OFS_CAPL)
            cap_q <= {temp_q, wrData};
    end

    // ---- compare channels ----
    tcc_compare_chan u_chanA (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .tick     (tick),
        .block    (block_q),
        .pwm      (pwm),
        .wrap     (wrap),
        .counter  (cnt_q),
        .wrLoad   (wrEn && addr_q == `TCC_OFS_CMPAL),
        .wrValue  ({temp_q, wrData}),
        .action   (actions_q[1:0]),
        .forceHit (wrEn && addr_q == `TCC_OFS_FORCE && wrData[0]),
        .active   (actA),
        .cpuView  (viewA),
        .match    (matchA),
        .outState (stateA)
    );

    tcc_compare_chan u_chanB (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .tick     (tick),
        .block    (block_q),
        .pwm      (pwm),
        .wrap     (wrap),
        .counter  (cnt_q),
        .wrLoad   (wrEn && addr_q == `TCC_OFS_CMPBL),
        .wrValue  ({temp_q, wrData}),
        .action   (actions_q[3:2]),
        .forceHit (wrEn && addr_q == `TCC_OFS_FORCE && wrData[1]),
        .active   (),
        .cpuView  (viewB),
        .match    (matchB),
        .outState (stateB)
    );

    // ---- flags: a set in the clearing cycle wins ----
    assign flagSet = {matchB, matchA, capEvent};
    assign flagClr = irqAck | ((wrEn && addr_q == `TCC_OFS_FLAGS)
                              ? wrData[2:0] : 3'b000);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            flags_q <= 3'b000;
        else
            flags_q <= (flags_q & ~flagClr) | flagSet;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            irqReq <= 3'b000;
        else
            irqReq <= flags_q & irqEn_q;
    end

    // ---- pins: direction always follows the port direction bits ----
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            cmpPinOut <= 2'b00;
            cmpPinOe  <= 2'b00;
        end
        else
        begin
            cmpPinOut[0] <= |actions_q[1:0] ? stateA : portVal_q[0];
            cmpPinOut[1] <= |actions_q[3:2] ? stateB : portVal_q[1];
            cmpPinOe     <= ddr_q;
        end
    end
endmodule // tcc_timer

// *** tcc_timer_monitor.sv ***
// checker for the timer's bus handshake and compare pin ports
// assumes it is bound into tcc_timer and sees its ports only
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_timer_monitor
    import tcc_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            resetn,
    input  tcc_pkg::tcc_ahb_req_t ahbReq,
    input  tcc_pkg::tcc_ahb_rsp_t ahbRsp,
    input  wire logic            capturePin,
    input  wire logic [2:0]      irqAck,
    input  wire logic [2:0]      irqReq,
    input  wire logic [1:0]      cmpPinOut,
    input  wire logic [1:0]      cmpPinOe
);
    logic       taken;
    logic       portWr;
    logic       wrPend_q;
    logic       rdPend_q;
    logic [7:0] addr_q;
    logic [3:0] act_q;
    logic [3:0] portW_q;
    assign taken = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready
                 & ahbRsp.hreadyout;
    assign portWr = wrPend_q && addr_q == `TCC_OFS_PORT;
    always_ff @(posedge clk_sys)
    begin
        wrPend_q <= resetn & taken & ahbReq.hwrite;
        if (taken)
            addr_q <= ahbReq.haddr[7:0];
    end
    // a read stays pending across its one wait state
    always_ff @(posedge clk_sys)
        rdPend_q <= resetn & (ahbRsp.hreadyout ? taken & !ahbReq.hwrite
                                               : rdPend_q);
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            act_q <= 4'h0;
        else if (wrPend_q && addr_q == `TCC_OFS_CTRLA)
            act_q <= ahbReq.hwdata[3:0];
        if (portWr)
            portW_q <= ahbReq.hwdata[3:0];
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence sRdWait;
        !ahbRsp.hreadyout ##1 ahbRsp.hreadyout;
    endsequence
    AST_RST_CLEAR: assert property (
        $rose(resetn) |-> cmpPinOut == 2'b00 && irqReq == 3'h0)
        else $error("outputs not clear after reset");
    AST_RD_WAIT: assert property (taken && !ahbReq.hwrite |=> sRdWait)
        else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (taken && ahbReq.hwrite |=>
        ahbRsp.hreadyout)
        else $error("write inserted a wait state");
    AST_OKAY: assert property (ahbRsp.hresp == 1'b0)
        else $error("response not okay");
    AST_HI_ZERO: assert property (ahbRsp.hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RD_STANDS: assert property (!rdPend_q |=> $stable(ahbRsp.hrdata))
        else $error("read data moved without a read");
    AST_OE_WRITE: assert property (
        portWr |=> ##[0:1] cmpPinOe == portW_q[3:2])
        else $error("pin direction does not follow port write");
    AST_OE_HOLD: assert property (
        $changed(cmpPinOe) |-> $past(portWr) || $past(portWr, 2))
        else $error("pin direction changed on its own");
    AST_PORT_PASS: assert property (
        portWr && act_q[1:0] == 2'b00 |=> ##[0:1]
        cmpPinOut[0] == portW_q[0])
        else $error("port value not on pin with action zero");
endmodule // tcc_timer_monitor
bind tcc_timer tcc_timer_monitor u_mon (
    .clk_sys(clk_sys), .resetn(resetn), .ahbReq(ahbReq),
    .ahbRsp(ahbRsp), .capturePin(capturePin), .irqAck(irqAck),
    .irqReq(irqReq), .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe));

// *** tcc_pin_partner.sv ***
// model of the pads around the timer: capture source and compare pads
// assumes the bench moves srcLevel just after a rising clock edge
`timescale 1ns/1ps
module tcc_pin_partner (
    input  wire logic       clk_sys,
    input  wire logic       srcLevel,
    input  wire logic [1:0] cmpPinOut,
    input  wire logic [1:0] cmpPinOe,
    output logic            capturePin,
    output logic      [1:0] padLevel
);
    logic [1:0] last_q = 2'b00;
    // port output or outside driver look alike to the sampler
    assign capturePin = srcLevel;
    // remember only driven levels; a released pad shows their inverse
    always @(posedge clk_sys)
        last_q <= (cmpPinOe & cmpPinOut) | (~cmpPinOe & last_q);
    assign padLevel = (cmpPinOe & cmpPinOut)
                    | (~cmpPinOe & ~last_q);
endmodule // tcc_pin_partner

// *** tcc_timer_tb.sv ***
// self-checking bench for the capture/compare timer
// assumes the checker binds itself into dut
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_timer_tb;
    import tcc_pkg::*;
    logic         clk_sys = 1'b0;
    logic         resetn = 1'b0;
    tcc_ahb_req_t req = '0;
    tcc_ahb_req_t busIn;
    tcc_ahb_rsp_t rsp;
    logic         src = 1'b0;
    logic         capPin;
    logic [2:0]   irqAck = 3'h0;
    logic [2:0]   irqReq;
    logic [1:0]   pinOut;
    logic [1:0]   pinOe;
    logic [1:0]   pad;
    logic         rdPh = 1'b0;
    logic [31:0]  expQ[$];
    int           nErrors = 0;
    int           nTests = 0;
    int           lat0;
    int           lat1;
    logic [7:0]   rnd = 8'h5A;
    logic [7:0]   hiA;
    logic [7:0]   acts [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
    logic [3:0]   outs = 4'h5;
    always #50 clk_sys = ~clk_sys;
    always_comb
    begin
        busIn = req;
        busIn.hready = rsp.hreadyout;
    end
    tcc_timer dut (.clk_sys(clk_sys), .resetn(resetn), .ahbReq(busIn),
        .ahbRsp(rsp), .capturePin(capPin), .irqAck(irqAck),
        .irqReq(irqReq), .cmpPinOut(pinOut), .cmpPinOe(pinOe));
    tcc_pin_partner pins (.clk_sys(clk_sys), .srcLevel(src),
        .cmpPinOut(pinOut), .cmpPinOe(pinOe), .capturePin(capPin),
        .padLevel(pad));
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic conclude();
        if (nErrors == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic giveUp();
        nErrors++;
        $display("Error at %0t: wait ran out", $time);
        conclude();
    endtask
    task automatic waitRdy();
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (rsp.hreadyout === 1'b1)
                return;
        end
        giveUp();
    endtask
    task automatic waitIrq(int b, output int n);
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk_sys);
            if (irqReq[b] === 1'b1)
                return;
        end
        giveUp();
    endtask
    task automatic bus(logic [7:0] a, logic w, logic [7:0] d);
        @(posedge clk_sys);
        req.hsel <= 1'b1;
        req.haddr <= {24'h0, a};
        req.htrans <= 2'b10;
        req.hwrite <= w;
        req.hsize <= 3'b010;
        waitRdy();
        req.htrans <= 2'b00;
        req.hwdata <= {24'h0, d};
        waitRdy();
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        expQ.push_back({24'h0, e});
        bus(a, 1'b0, 8'h00);
    endtask
    // read data is taken at the edge after the wait state, the first that sees hreadyout high
    always @(posedge clk_sys)
    begin
        if (rdPh && rsp.hreadyout === 1'b1)
        begin
            rdPh <= 1'b0;
            check(rsp.hrdata, expQ.pop_front());
        end
        if (busIn.hsel && busIn.htrans[1] && !busIn.hwrite
            && rsp.hreadyout === 1'b1)
            rdPh <= 1'b1;
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 16; i++)
            if (i != 2)
                rd(8'(4 * i), 8'h00);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00);
        check({30'h0, pinOut}, 32'h0);
        rnd = lfsr(rnd);
        hiA = rnd | 8'h80;
        wr(`TCC_OFS_CMPAH, hiA);
        rd(`TCC_OFS_CMPAH, 8'h00);
        rnd = lfsr(rnd);
        wr(`TCC_OFS_CMPAL, rnd);
        rd(`TCC_OFS_CMPAL, rnd);
        rd(`TCC_OFS_CMPAH, hiA);
        wr(`TCC_OFS_PORT, 8'h0C);
        for (int i = 0; i < 4; i++)
        begin
            wr(`TCC_OFS_CTRLA, acts[i]);
            wr(`TCC_OFS_FORCE, 8'h01);
            rd(`TCC_OFS_FLAGS, 8'h00);
            check({31'h0, pad[0]}, {31'h0, outs[i]});
        end
        wr(`TCC_OFS_CTRLA, 8'h00);
        wr(`TCC_OFS_PORT, 8'h0D);
        wr(`TCC_OFS_FORCE, 8'h01);
        rd(`TCC_OFS_CNTL, 8'h00);
        check({31'h0, pad[0]}, 32'h1);
        wr(`TCC_OFS_CTRLA, 8'h05);
        rd(`TCC_OFS_CNTL, 8'h00);
        check({30'h0, pad}, 32'h0);
        wr(`TCC_OFS_CMPBH, 8'h00);
        wr(`TCC_OFS_CMPBL, 8'h05);
        wr(`TCC_OFS_IRQEN, 8'h04);
        wr(`TCC_OFS_CTRLB, 8'h40);
        waitIrq(2, lat0);
        wr(`TCC_OFS_CTRLB, 8'h00);
        check({31'h0, pad[1]}, 32'h1);
        rd(`TCC_OFS_FLAGS, 8'h04);
        @(posedge clk_sys) irqAck <= 3'h4;
        @(posedge clk_sys) irqAck <= 3'h0;
        rd(`TCC_OFS_FLAGS, 8'h00);
        wr(`TCC_OFS_CNTH, 8'h00);
        wr(`TCC_OFS_CNTL, 8'h05);
        wr(`TCC_OFS_CTRLB, 8'h40);
        wr(`TCC_OFS_CTRLB, 8'h00);
        rd(`TCC_OFS_FLAGS, 8'h00);
        check({31'h0, pad[1]}, 32'h1);
        wr(`TCC_OFS_IRQEN, 8'h01);
        wr(`TCC_OFS_CNTH, 8'h12);
        wr(`TCC_OFS_CNTL, 8'h34);
        wr(`TCC_OFS_CTRLB, 8'h20);
        @(posedge clk_sys) src <= 1'b1;
        waitIrq(0, lat0);
        wr(`TCC_OFS_FLAGS, 8'h01);
        wr(`TCC_OFS_CNTH, 8'h56);
        wr(`TCC_OFS_CNTL, 8'h78);
        @(posedge clk_sys) src <= 1'b0;
        rd(`TCC_OFS_FLAGS, 8'h00);
        @(posedge clk_sys) src <= 1'b1;
        waitIrq(0, lat0);
        rd(`TCC_OFS_CAPL, 8'h78);
        rd(`TCC_OFS_CAPH, 8'h56);
        wr(`TCC_OFS_CTRLB, 8'h30);
        wr(`TCC_OFS_FLAGS, 8'h01);
        @(posedge clk_sys) src <= 1'b0;
        rd(`TCC_OFS_FLAGS, 8'h00);
        @(posedge clk_sys) src <= 1'b1;
        repeat (3) @(posedge clk_sys);
        src <= 1'b0;
        rd(`TCC_OFS_FLAGS, 8'h00);
        rd(`TCC_OFS_FLAGS, 8'h00);
        @(posedge clk_sys) src <= 1'b1;
        waitIrq(0, lat1);
        check(32'(lat1 - lat0), 32'h4);
        wr(`TCC_OFS_FLAGS, 8'h01);
        wr(`TCC_OFS_CAPH, 8'h9A);
        wr(`TCC_OFS_CAPL, 8'hBC);
        rd(`TCC_OFS_CAPL, 8'h78);
        wr(`TCC_OFS_CTRLB, 8'h2C);
        check({30'h0, pad}, 32'h2);
        wr(`TCC_OFS_CAPH, 8'h9A);
        wr(`TCC_OFS_CAPL, 8'hBC);
        rd(`TCC_OFS_CAPL, 8'hBC);
        rd(`TCC_OFS_CAPH, 8'h9A);
        @(posedge clk_sys) src <= 1'b0;
        rd(`TCC_OFS_FLAGS, 8'h00);
        @(posedge clk_sys) src <= 1'b1;
        rd(`TCC_OFS_FLAGS, 8'h00);
        rd(`TCC_OFS_FLAGS, 8'h00);
        wr(`TCC_OFS_CMPAH, 8'h00);
        wr(`TCC_OFS_CMPAL, 8'h01);
        wr(`TCC_OFS_CNTL, 8'h00);
        wr(`TCC_OFS_CTRLB, 8'h44);
        wr(`TCC_OFS_CTRLB, 8'h04);
        rd(`TCC_OFS_CNTL, 8'h01);
        rd(`TCC_OFS_FLAGS, 8'h02);
        wr(`TCC_OFS_CTRLB, 8'h0F);
        wr(`TCC_OFS_CMPAL, 8'h07);
        rd(`TCC_OFS_CMPAL, 8'h07);
        wr(`TCC_OFS_CNTL, 8'h01);
        wr(`TCC_OFS_CTRLB, 8'h4F);
        wr(`TCC_OFS_CTRLB, 8'h0F);
        rd(`TCC_OFS_CNTL, 8'h04);
        wr(`TCC_OFS_CNTL, 8'h00);
        wr(`TCC_OFS_CTRLB, 8'h4F);
        wr(`TCC_OFS_CTRLB, 8'h0F);
        rd(`TCC_OFS_CNTL, 8'h01);
        conclude();
    end
endmodule // tcc_timer_tb
